// ==== src/adc_acquisition_sequencer.sv ====
// Summary of operation
// - Single mode: one trigger write converts once and stores the result at once.
// - Status register index 8 bit 0 shows the converter FIFO empty.
// - Pacer mode converts on every sample clock pulse while the clock runs.
// - Each converted sample is pushed into the on-board FIFO for the host; the code drops it when the FIFO is full and sets overrun.
// - Post-trigger: acquire from trigger until N samples or software stop.
// - Delay-trigger: storing starts M sample clocks after trigger, M is 2..65535.
// - Delay-trigger ends after N stored samples or software stop.
// - About-trigger samples from start and stops N-M samples after trigger.
// - Pre-trigger acquires from start and stops at the trigger event; the code also stops after N samples if no trigger comes first.
// - Internal sample clock is a 16-bit divider of the 10 MHz base.
// - Internal rate spans 152.6 S/s to 2 MS/s.
// - External clock selected: convert on each rising edge of that input.
// - Clock source choice applies to pacer, post, delay and about modes.
// - Trigger comes from software, external digital input or threshold comparator.
// - Trigger edge is selectable rising or falling.
// - Per-channel polarity and gain; gain 0.5 only when bipolar.
// - Writing the trigger flag at index 6 makes the software trigger edge.
//
// Design decisions made here: the Wishbone slave port and the address map.
module adc_acquisition_sequencer
    import adc_seq_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire wb_req_t wb_req,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic ext_sample_clock_in,
    input wire logic ext_digital_trigger_in,
    input wire logic threshold_trigger_in,
    input wire logic [11:0] adc_data,
    output logic conv_start,
    output logic [3:0] cur_chan,
    output logic [3:0] cur_range
);
    typedef struct packed {
        st_t st;
        mode_t mode;
        logic clk_ext;
        trig_src_t tsrc;
        logic tfall;
        logic [3:0] last_chan;
        logic [15:0] div;
        logic [15:0] div_cnt;
        logic itick;
        logic [15:0] n_cnt;
        logic [15:0] m_cnt;
        logic [15:0] smp_cnt;
        logic [15:0] dly_cnt;
        logic [15:0] post_cnt;
        logic trig_seen;
        logic overrun;
        logic soft_trigger_flag;
        logic trig_prev;
        logic [2:0] eclk_s;
        logic [2:0] etrg_s;
        logic [2:0] thr_s;
        logic [15:0][3:0] range;
        logic [3:0] chan;
        logic [3:0] crange;
        logic [FIFO_DEPTH-1:0][11:0] mem;
        logic [FIFO_AW:0] wp;
        logic [FIFO_AW:0] rp;
        logic ack;
        logic [31:0] rdat;
        logic conv;
    } state_t;

    state_t q, d;
    logic take, wr, rd, halt, fifo_empty, fifo_full, tick, trig_lvl, trig_ev, store;
    logic [7:0] idx;
    logic [3:0] rng;

    // Bus request taken only while no answer is pending
    assign take = wb_req.cyc && wb_req.stb && !q.ack;
    assign wr = take && wb_req.we;
    assign rd = take && !wb_req.we;
    assign halt = wr && idx == IDX_CTRL && wb_req.dat[CTRL_STOP];
    assign idx = {2'b00, wb_req.adr[7:2]};
    assign fifo_empty = (q.wp == q.rp);
    assign fifo_full = ((q.wp ^ q.rp) == FIFO_FULL_XOR);

    always_comb begin
        d = q;
        d.ack = take;
        d.conv = 1'b0;
        d.itick = 1'b0;
        store = 1'b0;
        rng = 4'h0;
        // Two-stage synchronisers; stage 0 feeds only stage 1
        d.eclk_s = {q.eclk_s[1:0], ext_sample_clock_in};
        d.etrg_s = {q.etrg_s[1:0], ext_digital_trigger_in};
        d.thr_s = {q.thr_s[1:0], threshold_trigger_in};
        // Divider reloads at terminal count; its pulse is the counter output edge
        if (q.div_cnt <= 16'h0001) begin
            d.div_cnt = q.div;
            d.itick = 1'b1;
        end else begin
            d.div_cnt = q.div_cnt - 16'h0001;
        end
        // Clock source pick applies to every clocked mode
        tick = q.clk_ext ? (q.eclk_s[1] && !q.eclk_s[2]) : q.itick;
        // Trigger source mux and edge detector
        case (q.tsrc)
            TRIG_EXT: trig_lvl = q.etrg_s[1];
            TRIG_THRESH: trig_lvl = q.thr_s[1];
            default: trig_lvl = q.soft_trigger_flag;
        endcase
        d.trig_prev = trig_lvl;
        trig_ev = q.tfall ? (q.trig_prev && !trig_lvl) : (!q.trig_prev && trig_lvl);
        // Acquisition sequencer
        case (q.st)
            ST_WAIT: begin
                if (trig_ev) begin
                    d.trig_seen = 1'b1;
                    d.dly_cnt = 16'h0000;
                    d.st = (q.mode == MODE_DELAY) ? ST_DELAY : ST_RUN;
                end
            end
            ST_DELAY: begin
                // Ticks are counted but nothing is stored until M have passed
                if (tick) begin
                    d.dly_cnt = q.dly_cnt + 16'h0001;
                    if (d.dly_cnt >= q.m_cnt) begin
                        d.st = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                store = tick && !halt;
                if (store) begin
                    d.smp_cnt = q.smp_cnt + 16'h0001;
                end
                if (store && q.trig_seen) begin
                    d.post_cnt = q.post_cnt + 16'h0001;
                end
                if (trig_ev && !q.trig_seen &&
                    (q.mode == MODE_ABOUT || q.mode == MODE_PRE)) begin
                    d.trig_seen = 1'b1;
                end
                case (q.mode)
                    MODE_POST, MODE_DELAY: begin
                        if (d.smp_cnt >= q.n_cnt) begin
                            d.st = ST_IDLE;
                        end
                    end
                    MODE_ABOUT: begin
                        if (q.trig_seen && d.post_cnt >= (q.n_cnt - q.m_cnt)) begin
                            d.st = ST_IDLE;
                        end
                    end
                    MODE_PRE: begin
                        if (d.trig_seen || d.smp_cnt >= q.n_cnt) begin
                            d.st = ST_IDLE;
                        end
                    end
                    default: ;
                endcase
            end
            default: ;
        endcase
        // Single mode converts straight from the trigger write
        if (wr && idx == IDX_TRIG && q.mode == MODE_SINGLE && q.st == ST_IDLE) begin
            store = 1'b1;
        end
        // Every conversion lands in the FIFO; a full FIFO drops it and flags overrun
        if (store) begin
            d.conv = 1'b1;
            d.chan = (q.chan >= q.last_chan) ? 4'h0 : q.chan + 4'h1;
            if (!fifo_full) begin
                d.mem[q.wp[FIFO_AW-1:0]] = adc_data;
                d.wp = q.wp + 5'h01;
            end
        end
        d.crange = q.range[d.chan];
        // Register reads; a data read pops the FIFO
        d.rdat = 32'h0000_0000;
        if (rd) begin
            if (idx == IDX_CTRL) begin
                d.rdat = {16'h0000, q.last_chan, 5'h00, q.tfall, q.tsrc, q.clk_ext, q.mode};
            end else if (idx == IDX_DIV) begin
                d.rdat = {16'h0000, q.div};
            end else if (idx == IDX_NCNT) begin
                d.rdat = {16'h0000, q.n_cnt};
            end else if (idx == IDX_MCNT) begin
                d.rdat = {16'h0000, q.m_cnt};
            end else if (idx == IDX_DATA) begin
                d.rdat = {20'h0_0000, q.mem[q.rp[FIFO_AW-1:0]]};
                if (!fifo_empty) begin
                    d.rp = q.rp + 5'h01;
                end
            end else if (idx == IDX_TRIG) begin
                d.rdat = {31'h0000_0000, q.soft_trigger_flag};
            end else if (idx == IDX_COUNT) begin
                d.rdat = {16'h0000, q.smp_cnt};
            end else if (idx == IDX_STAT) begin
                d.rdat = {27'h000_0000, q.trig_seen, q.overrun, q.st != ST_IDLE,
                          fifo_full, fifo_empty};
                d.overrun = 1'b0;
            end
        end
        // Register writes; start and stop override the sequencer
        if (wr) begin
            if (idx == IDX_CTRL) begin
                d.mode = mode_t'(wb_req.dat[2:0]);
                d.clk_ext = wb_req.dat[CTRL_CLK_EXT];
                d.tsrc = trig_src_t'(wb_req.dat[5:4]);
                d.tfall = wb_req.dat[CTRL_TFALL];
                d.last_chan = wb_req.dat[CTRL_LAST_LO +: 4];
                if (wb_req.dat[CTRL_STOP]) begin
                    d.st = ST_IDLE;
                end else if (wb_req.dat[CTRL_START]) begin
                    d.smp_cnt = 16'h0000;
                    d.post_cnt = 16'h0000;
                    d.dly_cnt = 16'h0000;
                    d.trig_seen = 1'b0;
                    d.chan = 4'h0;
                    d.div_cnt = q.div;
                    case (mode_t'(wb_req.dat[2:0]))
                        MODE_PACER, MODE_ABOUT, MODE_PRE: d.st = ST_RUN;
                        MODE_POST, MODE_DELAY: d.st = ST_WAIT;
                        default: d.st = ST_IDLE;
                    endcase
                end
            end else if (idx == IDX_DIV) begin
                // Divisor below the top rate is clamped to the 2 MS/s setting
                d.div = (wb_req.dat[15:0] < DIV_MIN) ? DIV_MIN : wb_req.dat[15:0];
            end else if (idx == IDX_NCNT) begin
                d.n_cnt = wb_req.dat[15:0];
            end else if (idx == IDX_MCNT) begin
                d.m_cnt = wb_req.dat[15:0];
            end else if (idx == IDX_RANGE) begin
                // Unipolar cannot take gain 0.5, fall back to unity
                rng = wb_req.dat[3:0];
                if (rng[2:0] > GAIN_MAX) begin
                    rng[2:0] = GAIN_MAX;
                end
                if (!rng[3] && rng[2:0] == GAIN_HALF) begin
                    rng[2:0] = GAIN_ONE;
                end
                d.range[wb_req.dat[19:16]] = rng;
            end else if (idx == IDX_TRIG) begin
                d.soft_trigger_flag = wb_req.dat[0];
            end
        end
        // Overrun set beats a same-cycle status read clear
        if (store && fifo_full) begin
            d.overrun = 1'b1;
        end
    end

    // Whole block state
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.div <= DIV_RST;
            q.n_cnt <= NCNT_RST;
            q.m_cnt <= MCNT_RST;
            q.range <= {16{RANGE_RST}};
            q.crange <= RANGE_RST;
        end else begin
            q <= d;
        end
    end

    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdat;
    assign conv_start = q.conv;
    assign cur_chan = q.chan;
    assign cur_range = q.crange;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_clk_rise;
        !q.eclk_s[1] ##1 q.eclk_s[1];
    endsequence
    sequence s_run_ext;
        q.st == ST_RUN && q.clk_ext && !halt;
    endsequence

    property p_single_conv;
        wr && idx == IDX_TRIG && q.mode == MODE_SINGLE && q.st == ST_IDLE |=> conv_start;
    endproperty
    a_single_conv: assert property (p_single_conv) else $error("single trigger lost");

    property p_stat_empty;
        rd && idx == IDX_STAT |=> wb_dat_o[STAT_EMPTY] == $past(fifo_empty);
    endproperty
    a_stat_empty: assert property (p_stat_empty) else $error("empty flag wrong");

    property p_ext_pacer;
        s_clk_rise ##0 s_run_ext |=> conv_start;
    endproperty
    a_ext_pacer: assert property (p_ext_pacer) else $error("ext edge no conv");

    property p_push;
        conv_start && !$past(fifo_full) |-> !fifo_empty || $past(rd);
    endproperty
    a_push: assert property (p_push) else $error("sample not stored");

    property p_post_limit;
        q.st == ST_RUN && q.mode == MODE_POST && q.n_cnt != 16'h0000 |-> q.smp_cnt < q.n_cnt;
    endproperty
    a_post_limit: assert property (p_post_limit) else $error("post count overrun");

    property p_delay_quiet;
        q.st == ST_DELAY && $past(q.st) == ST_DELAY |-> !conv_start;
    endproperty
    a_delay_quiet: assert property (p_delay_quiet) else $error("store during delay");

    property p_div_gap;
        !q.clk_ext && q.itick |=> !q.itick [*4];
    endproperty
    a_div_gap: assert property (p_div_gap) else $error("rate above 2 MS/s");

    property p_stop;
        wr && idx == IDX_CTRL && wb_req.dat[CTRL_STOP]
            |=> q.st == ST_IDLE && q.wp == $past(q.wp) && $stable(q.smp_cnt);
    endproperty
    a_stop: assert property (p_stop) else $error("stop not clean");

    property p_uni_gain;
        !(cur_range[3] == 1'b0 && cur_range[2:0] == GAIN_HALF);
    endproperty
    a_uni_gain: assert property (p_uni_gain) else $error("unipolar gain 0.5");
endmodule

// ==== src/adc_seq_pkg.sv ====
package adc_seq_pkg;
    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h00;
    localparam logic [7:0] IDX_DIV = 8'h01;
    localparam logic [7:0] IDX_NCNT = 8'h02;
    localparam logic [7:0] IDX_MCNT = 8'h03;
    localparam logic [7:0] IDX_RANGE = 8'h04;
    localparam logic [7:0] IDX_DATA = 8'h05;
    localparam logic [7:0] IDX_TRIG = 8'h06;
    localparam logic [7:0] IDX_COUNT = 8'h07;
    localparam logic [7:0] IDX_STAT = 8'h08;
    // Control register fields
    localparam int CTRL_CLK_EXT = 3;
    localparam int CTRL_TFALL = 6;
    localparam int CTRL_START = 8;
    localparam int CTRL_STOP = 9;
    localparam int CTRL_LAST_LO = 12;
    // Status register fields
    localparam int STAT_EMPTY = 0;
    localparam int STAT_FULL = 1;
    localparam int STAT_BUSY = 2;
    localparam int STAT_OVR = 3;
    localparam int STAT_TRIG = 4;
    // Sample clock timing
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned MAX_RATE_HZ = 2_000_000;
    localparam logic [15:0] DIV_MIN = 16'(CLK_HZ / MAX_RATE_HZ);
    // Values after reset, then FIFO geometry
    localparam logic [15:0] DIV_RST = 16'h000A;
    localparam logic [15:0] NCNT_RST = 16'h0001;
    localparam logic [15:0] MCNT_RST = 16'h0002;
    localparam logic [3:0] RANGE_RST = 4'h1;
    localparam int FIFO_AW = 4;
    localparam int FIFO_DEPTH = 16;
    localparam logic [4:0] FIFO_FULL_XOR = 5'h10;

    typedef enum logic [2:0] {
        MODE_SINGLE = 3'h0, MODE_PACER = 3'h1, MODE_POST = 3'h2,
        MODE_DELAY = 3'h3, MODE_ABOUT = 3'h4, MODE_PRE = 3'h5
    } mode_t;
    typedef enum logic [1:0] {
        TRIG_SOFT = 2'h0, TRIG_EXT = 2'h1, TRIG_THRESH = 2'h2
    } trig_src_t;
    // Gray order along idle, wait, delay, run
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_WAIT = 2'b01, ST_DELAY = 2'b11, ST_RUN = 2'b10
    } st_t;
    // Range entry: bit 3 bipolar, bits 2:0 gain code 0=x0.5 1=x1 2=x2 3=x4 4=x8
    localparam logic [2:0] GAIN_HALF = 3'h0;
    localparam logic [2:0] GAIN_ONE = 3'h1;
    localparam logic [2:0] GAIN_MAX = 3'h4;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } wb_req_t;
endpackage

// ==== tb/adc_acquisition_sequencer_bench.sv ====
module adc_acquisition_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import adc_seq_pkg::*;
    logic mclk, nrst, ext_clk, ext_trg, thr_trg, conv_start, ack, clk_run;
    logic [31:0] rdat, q, c1;
    logic [11:0] adc_data;
    logic [3:0] cur_chan, cur_range;
    wb_req_t req;
    int fail_count, num_checks, cyc_n, t0;

    adc_acquisition_sequencer u_dut (.mclk(mclk), .nrst(nrst), .wb_req(req),
        .wb_ack_o(ack), .wb_dat_o(rdat), .ext_sample_clock_in(ext_clk),
        .ext_digital_trigger_in(ext_trg), .threshold_trigger_in(thr_trg),
        .adc_data(adc_data), .conv_start(conv_start), .cur_chan(cur_chan),
        .cur_range(cur_range));
    converter_model u_conv (.mclk(mclk), .nrst(nrst), .conv_start(conv_start),
        .clk_run(clk_run), .adc_data(adc_data), .ext_clk(ext_clk));

    // 100 ns clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = !mclk;
    end
    // Hang guard: whole run needs under a thousand cycles
    always @(posedge mclk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            fail_count = fail_count + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Classic cycle: hold until ack is sampled, release at that edge
    task automatic bus(input logic we, input logic [7:0] idx, input logic [31:0] d);
        @(posedge mclk);
        req <= '{1'b1, 1'b1, we, 4'hF, {idx[5:0], 2'b00}, d};
        do @(posedge mclk); while (ack !== 1'b1);
        q = rdat;
        req <= '0;
    endtask

    task automatic wait_idle();
        bus(1'b0, IDX_STAT, 32'h0);
        while (q[STAT_BUSY] !== 1'b0) bus(1'b0, IDX_STAT, 32'h0);
    endtask

    task automatic wait_pulse(output int t);
        do @(posedge mclk); while (conv_start !== 1'b1);
        t = cyc_n;
    endtask

    initial begin
        req = '0;
        nrst = 1'b0;
        ext_trg = 1'b1;
        thr_trg = 1'b0;
        clk_run = 1'b0;
        fail_count = 0;
        num_checks = 0;
        cyc_n = 0;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        // Status after reset: FIFO empty, nothing stored
        bus(1'b0, IDX_STAT, 32'h0);
        chk({31'h0, q[STAT_EMPTY]}, 32'h0000_0001);
        chk({28'h0, cur_range}, 32'h0000_0001);
        chk({28'h0, cur_chan}, 32'h0000_0000);
        // Unipolar gain 0.5 falls back to unity; an out-of-range code is clamped to x8
        bus(1'b1, IDX_RANGE, 32'h0000_0000);
        @(posedge mclk);
        chk({28'h0, cur_range}, 32'h0000_0001);
        bus(1'b1, IDX_RANGE, 32'h0000_000F);
        @(posedge mclk);
        chk({28'h0, cur_range}, 32'h0000_000C);
        $display("test reset done");
        // Single mode: one write converts once, result at once
        bus(1'b1, IDX_TRIG, 32'h0);
        repeat (4) @(posedge mclk);
        bus(1'b0, IDX_STAT, 32'h0);
        chk({31'h0, q[STAT_EMPTY]}, 32'h0000_0000);
        bus(1'b0, IDX_DATA, 32'h0);
        chk(q, 32'h0000_00A5);
        bus(1'b0, IDX_STAT, 32'h0);
        chk({31'h0, q[STAT_EMPTY]}, 32'h0000_0001);
        $display("test single done");
        // Post-trigger, soft rising edge, N=3: waits, then stores three
        // Divisor below the top rate reads back clamped; then 17 keeps under 600 kS/s
        bus(1'b1, IDX_DIV, 32'h0000_0002);
        bus(1'b0, IDX_DIV, 32'h0);
        chk(q, {16'h0000, DIV_MIN});
        bus(1'b1, IDX_DIV, 32'h0000_0011);
        bus(1'b1, IDX_NCNT, 32'h0000_0003);
        bus(1'b1, IDX_CTRL, 32'h0000_0102);
        repeat (30) @(posedge mclk);
        bus(1'b0, IDX_COUNT, 32'h0);
        chk(q, 32'h0000_0000);
        bus(1'b1, IDX_TRIG, 32'h0000_0001);
        wait_idle();
        bus(1'b0, IDX_COUNT, 32'h0);
        chk(q, 32'h0000_0003);
        for (int k = 0; k < 3; k++) begin
            bus(1'b0, IDX_DATA, 32'h0);
            chk(q, 32'h0000_00A6 + k);
        end
        $display("test post done");
        // Pacer, internal divider 17: pulse every 17 cycles until stopped
        bus(1'b1, IDX_CTRL, 32'h0000_0101);
        wait_pulse(t0);
        wait_pulse(c1);
        chk(c1 - t0, 32'h0000_0011);
        wait_pulse(t0);
        chk(t0 - c1, 32'h0000_0011);
        bus(1'b1, IDX_CTRL, 32'h0000_0200);
        bus(1'b0, IDX_COUNT, 32'h0);
        c1 = q;
        repeat (20) @(posedge mclk);
        bus(1'b0, IDX_COUNT, 32'h0);
        chk(q, c1);
        bus(1'b0, IDX_STAT, 32'h0);
        chk({31'h0, q[STAT_BUSY | 0]}, 32'h0000_0000);
        for (int k = 0; k < 20; k++) bus(1'b0, IDX_DATA, 32'h0);
        $display("test pacer done");
        // Delay-trigger: external clock, external trigger on falling edge
        bus(1'b1, IDX_NCNT, 32'h0000_0002);
        bus(1'b1, IDX_MCNT, 32'h0000_0002);
        bus(1'b1, IDX_CTRL, 32'h0000_015B);
        clk_run <= 1'b1;
        repeat (40) @(posedge mclk);
        bus(1'b0, IDX_COUNT, 32'h0);
        chk(q, 32'h0000_0000);
        ext_trg <= 1'b0;
        wait_idle();
        clk_run <= 1'b0;
        bus(1'b0, IDX_COUNT, 32'h0);
        chk(q, 32'h0000_0002);
        $display("test delay done");
        // Pre-trigger: runs from start, stops at threshold rising edge
        bus(1'b1, IDX_NCNT, 32'h0000_0064);
        bus(1'b1, IDX_CTRL, 32'h0000_0125);
        repeat (30) @(posedge mclk);
        thr_trg <= 1'b1;
        wait_idle();
        chk({31'h0, q[STAT_TRIG]}, 32'h0000_0001);
        bus(1'b0, IDX_COUNT, 32'h0);
        c1 = q;
        repeat (20) @(posedge mclk);
        bus(1'b0, IDX_COUNT, 32'h0);
        chk(q, c1);
        chk({31'h0, c1 > 0}, 32'h0000_0001);
        $display("test pre done");
        // About-trigger, soft rising edge, N=4 M=2, scan 0..1: N-M samples follow the trigger
        bus(1'b1, IDX_TRIG, 32'h0000_0000);
        bus(1'b1, IDX_NCNT, 32'h0000_0004);
        bus(1'b1, IDX_MCNT, 32'h0000_0002);
        bus(1'b1, IDX_CTRL, 32'h0000_1104);
        repeat (60) @(posedge mclk);
        // Trigger lands a few cycles after a sample, well before the next tick
        wait_pulse(t0);
        bus(1'b0, IDX_COUNT, 32'h0);
        c1 = q;
        bus(1'b1, IDX_TRIG, 32'h0000_0001);
        wait_idle();
        bus(1'b0, IDX_COUNT, 32'h0);
        chk(q, c1 + 32'h0000_0002);
        chk({28'h0, cur_chan}, (c1 + 32'h0000_0002) & 32'h0000_0001);
        $display("test about done");
        give_verdict();
    end
endmodule

// ==== tb/converter_model.sv ====
// Far-side model: converter result source and external sample clock
module converter_model (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic conv_start,
    input wire logic clk_run,
    output logic [11:0] adc_data,
    output logic ext_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] n_q;
    logic [3:0] ph_q;
    // Result steps after each conversion so FIFO order is visible
    assign adc_data = 12'h0A5 + n_q;
    // Clock halves of 9 cycles give about 556 kHz: under the pin limit and the scan rate limit
    // Idle low between runs
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            n_q <= 12'h000;
            ph_q <= 4'h0;
            ext_clk <= 1'b0;
        end else begin
            if (conv_start) n_q <= n_q + 12'h001;
            ph_q <= (ph_q == 4'h8 || !clk_run) ? 4'h0 : ph_q + 4'h1;
            if (!clk_run) ext_clk <= 1'b0;
            else if (ph_q == 4'h8) ext_clk <= !ext_clk;
        end
    end
endmodule
